/* File: logic/mae_params.svh */
`ifndef MAE_PARAMS_SVH
`define MAE_PARAMS_SVH

`define MAE_CLK_HZ        28'hEE6B280
`define MAE_CLK_KHZ       250000
`define MAE_SHOT_MS       200
`define MAE_AW            12
`define MAE_RAM_DEPTH     4096
`define MAE_FIFO_DEPTH    32
`define MAE_RATE_W        20
`define MAE_LEN_W         16

`define MAE_A_EFFECT      8'h00
`define MAE_A_SYN_TRIG    8'h04
`define MAE_A_SYN_VOL     8'h08
`define MAE_A_PB_START    8'h0C
`define MAE_A_PB_LEN      8'h10
`define MAE_A_PB_RATE     8'h14
`define MAE_A_PB_FMT      8'h18
`define MAE_A_PB_LOOP     8'h1C
`define MAE_A_PB_TRIG     8'h20
`define MAE_A_PB_VOL      8'h24
`define MAE_A_PB_PTR      8'h28

`define MAE_MID_C_OFS     9'h084
`define MAE_SEMIS         9'h00C
`define MAE_OCT_BASE      11
`define MAE_SHOT_BASE     8'h40
`define MAE_LFSR_SEED     16'hACE1
`define MAE_LFSR_TAPS     16'hB400
`define MAE_ADPCM_IDX_MAX 7'h58
`define MAE_MU_BIAS       16'h0084

`endif

/* File: logic/mae_pkg.sv */
`include "mae_params.svh"
`default_nettype none
package mae_pkg;
  typedef enum logic [1:0] {
    fmt_linear = 2'h0,
    fmt_mulaw  = 2'h1,
    fmt_adpcm  = 2'h2
  } mae_fmt_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mae_reg_req_s;

  typedef struct packed {
    logic                 wr;
    logic [`MAE_AW-1:0]   addr;
    logic [7:0]           data;
  } mae_ram_wr_s;

  typedef struct packed {
    logic signed [15:0] pred;
    logic [6:0]         idx;
  } mae_adpcm_s;

  typedef struct packed {
    logic [15:0]            effect;
    logic                   syn_play;
    logic [7:0]             syn_vol;
    logic [31:0]            syn_ph;
    logic [31:0]            syn_cnt;
    logic [15:0]            lfsr;
    logic [7:0]             syn_smp;
    logic [`MAE_AW-1:0]     pb_start;
    logic [`MAE_LEN_W-1:0]  pb_len;
    logic [`MAE_RATE_W-1:0] pb_rate;
    mae_fmt_e               fmt;
    logic                   loop;
    logic                   pb_play;
    logic [7:0]             pb_vol;
    logic [`MAE_AW-1:0]     ptr;
    logic [`MAE_LEN_W-1:0]  played;
    logic [`MAE_AW-1:0]     f_addr;
    logic [`MAE_LEN_W-1:0]  f_left;
    logic                   inflight;
    logic                   nib_ph;
    logic [7:0]             nib_byte;
    mae_adpcm_s             adp;
    logic [15:0]            pb_smp;
    logic [27:0]            acc;
    logic [7:0]             pwm_cnt;
    logic [7:0]             duty;
    logic                   pwm;
    logic [31:0]            rdata;
  } mae_state_s;
endpackage
`default_nettype wire

/* File: logic/mae_ram.sv */
`default_nettype none
module mae_ram #(
  parameter int W     = 8,
  parameter int DEPTH = 4096
) (
  input  wire logic                     clk_i,
  input  wire logic                     wr_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [W-1:0]             wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [W-1:0]             rdata_o
);
  logic [W-1:0] mem_q [DEPTH];

  // read returns old data on a same-address write
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule
`default_nettype wire

/* File: logic/mae_fifo.sv */
`default_nettype none
module mae_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_ff != (AW+1)'(D));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_q[rp_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (flush_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= push ? AW'(wp_ff + 1'b1) : wp_ff;
      rp_ff  <= pop ? AW'(rp_ff + 1'b1) : rp_ff;
      cnt_ff <= (AW+1)'(cnt_ff + push - pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_ff] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: logic/mae_top.sv */
`include "mae_params.svh"
`default_nettype none
module mae_top #(
  parameter int unsigned SHOT_CYC = `MAE_SHOT_MS * `MAE_CLK_KHZ
) (
  input  wire logic                  mclk_i,
  input  wire logic                  arst_n_i,
  input  wire mae_pkg::mae_reg_req_s reg_req_i,
  input  wire mae_pkg::mae_ram_wr_s  ram_wr_i,
  output logic [31:0]                reg_rdata_o,
  output logic                       audio_pwm_o
);
  import mae_pkg::*;

  logic [1:0]   rsync_ff;
  logic         rst_n;
  mae_state_s   s_ff;
  mae_state_s   nxt_s;
  logic         tick;
  logic         byte_done;
  logic         flush;
  logic         fifo_pop;
  logic         fifo_ir;
  logic         fifo_ov;
  logic [7:0]   fifo_od;
  logic [7:0]   ram_rdata;
  logic [3:0]   nib;
  logic [28:0]  acc_sum;
  logic [15:0]  syn_v;
  logic [15:0]  pb_v;
  logic [16:0]  mix_sum;
  logic [15:0]  mix;
  logic         wr_hit;

  // IMA-style decode; step size follows an exponent/mantissa curve
  function automatic mae_adpcm_s adpcm_dec(input mae_adpcm_s st, input logic [3:0] n);
    logic [15:0]        step;
    logic [16:0]        diff;
    logic signed [17:0] p;
    logic [7:0]         ix;
    mae_adpcm_s         r;
    step = 16'({1'b1, st.idx[2:0]}) << st.idx[6:3];
    diff = 17'(step >> 3);
    if (n[0]) diff = 17'(diff + (step >> 2));
    if (n[1]) diff = 17'(diff + (step >> 1));
    if (n[2]) diff = 17'(diff + step);
    p = n[3] ? 18'(18'(st.pred) - 18'(diff)) : 18'(18'(st.pred) + 18'(diff));
    if (p[17:15] != {3{p[17]}}) r.pred = p[17] ? 16'sh8000 : 16'sh7FFF;
    else r.pred = p[15:0];
    ix = 8'(8'(st.idx) + (n[2] ? 8'({n[1:0], 1'b0}) + 8'h02 : 8'hFF));
    if (ix[7]) r.idx = '0;
    else if (ix[6:0] > `MAE_ADPCM_IDX_MAX) r.idx = `MAE_ADPCM_IDX_MAX;
    else r.idx = ix[6:0];
    return r;
  endfunction

  function automatic logic [15:0] mulaw_dec(input logic [7:0] b);
    logic [7:0]  u;
    logic [15:0] m;
    u = ~b;
    m = 16'((16'({u[3:0], 3'h0}) + `MAE_MU_BIAS) << u[6:4]);
    m = 16'(m - `MAE_MU_BIAS);
    return u[7] ? 16'(-m) : m;
  endfunction

  function automatic logic [15:0] vscale(input logic [15:0] x, input logic [7:0] v);
    logic signed [24:0] p;
    p = $signed(x) * $signed({1'b0, v});
    return p[23:8];
  endfunction

  // note 0 is middle C; equal-tempered semitone steps, octaves by shifting
  function automatic logic [31:0] note_inc(input logic [7:0] note);
    logic [8:0]  u;
    logic [4:0]  oct;
    logic [3:0]  semi;
    logic [15:0] t;
    logic [47:0] x;
    u    = 9'(9'($signed(note)) + `MAE_MID_C_OFS);
    oct  = 5'(u / `MAE_SEMIS);
    semi = 4'(u % `MAE_SEMIS);
    case (semi)
      4'h0:    t = 16'h118F;
      4'h1:    t = 16'h129A;
      4'h2:    t = 16'h13B5;
      4'h3:    t = 16'h14E1;
      4'h4:    t = 16'h161F;
      4'h5:    t = 16'h1770;
      4'h6:    t = 16'h18D5;
      4'h7:    t = 16'h1A4F;
      4'h8:    t = 16'h1BDF;
      4'h9:    t = 16'h1D88;
      4'hA:    t = 16'h1F49;
      default: t = 16'h2125;
    endcase
    x = 48'(t) << oct;
    return 32'(x >> `MAE_OCT_BASE);
  endfunction

  function automatic logic [7:0] wave(input logic [1:0] w, input logic [31:0] p);
    case (w)
      2'h0:    wave = p[31] ? 8'h81 : 8'h7F;
      2'h1:    wave = p[31:24] ^ 8'h80;
      2'h2:    wave = (p[31] ? ~p[30:23] : p[30:23]) ^ 8'h80;
      default: wave = (p[31:30] == 2'h0) ? 8'h7F : 8'h81;
    endcase
  endfunction

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) rsync_ff <= 2'h0;
    else rsync_ff <= {rsync_ff[0], 1'b1};
  end
  assign rst_n = rsync_ff[1];

  mae_ram #(
    .W     (8),
    .DEPTH (`MAE_RAM_DEPTH)
  ) u_ram (
    .clk_i   (mclk_i),
    .wr_i    (ram_wr_i.wr),
    .waddr_i (ram_wr_i.addr),
    .wdata_i (ram_wr_i.data),
    .raddr_i (s_ff.f_addr),
    .rdata_o (ram_rdata)
  );

  mae_fifo #(
    .W (8),
    .D (`MAE_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (mclk_i),
    .rst_n_i     (rst_n),
    .flush_i     (flush),
    .in_valid_i  (s_ff.inflight),
    .in_ready_o  (fifo_ir),
    .in_data_i   (ram_rdata),
    .out_valid_o (fifo_ov),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_od)
  );

  assign syn_v   = vscale({s_ff.syn_smp, 8'h00}, s_ff.syn_vol);
  assign pb_v    = vscale(s_ff.pb_smp, s_ff.pb_vol);
  assign mix_sum = 17'({syn_v[15], syn_v} + {pb_v[15], pb_v});
  assign mix     = (mix_sum[16] != mix_sum[15]) ? (mix_sum[16] ? 16'h8000 : 16'h7FFF) : mix_sum[15:0];
  assign nib     = s_ff.nib_ph ? s_ff.nib_byte[7:4] : fifo_od[3:0];
  assign acc_sum = 29'(s_ff.acc) + 29'(s_ff.pb_rate);
  assign wr_hit  = reg_req_i.wr;

  always_comb begin
    nxt_s     = s_ff;
    tick      = 1'b0;
    byte_done = 1'b0;
    flush     = 1'b0;
    fifo_pop  = 1'b0;
    nxt_s.inflight = 1'b0;

    nxt_s.lfsr = (s_ff.lfsr == '0) ? `MAE_LFSR_SEED :
                 ({1'b0, s_ff.lfsr[15:1]} ^ (s_ff.lfsr[0] ? `MAE_LFSR_TAPS : 16'h0000));
    if (!s_ff.syn_play) begin
      nxt_s.syn_smp = '0;
    end else if (s_ff.effect[7:0] < `MAE_SHOT_BASE) begin
      nxt_s.syn_ph  = 32'(s_ff.syn_ph + note_inc(s_ff.effect[15:8]));
      nxt_s.syn_smp = wave(s_ff.effect[1:0], s_ff.syn_ph);
    end else begin
      // noise burst at a fixed rate, high byte unused
      nxt_s.syn_smp = s_ff.lfsr[7:0];
      nxt_s.syn_cnt = 32'(s_ff.syn_cnt + 1'b1);
      if (s_ff.syn_cnt == 32'(SHOT_CYC - 1)) nxt_s.syn_play = 1'b0;
    end

    // fractional accumulator gives an average rate of pb_rate ticks per second
    if (s_ff.pb_play) begin
      if (acc_sum >= 29'(`MAE_CLK_HZ)) begin
        tick      = 1'b1;
        nxt_s.acc = 28'(acc_sum - 29'(`MAE_CLK_HZ));
      end else begin
        nxt_s.acc = 28'(acc_sum);
      end
    end

    if (tick) begin
      if (s_ff.fmt == fmt_adpcm && (s_ff.nib_ph || fifo_ov)) begin
        nxt_s.adp    = adpcm_dec(s_ff.adp, nib);
        nxt_s.pb_smp = nxt_s.adp.pred;
        nxt_s.nib_ph = ~s_ff.nib_ph;
        fifo_pop     = ~s_ff.nib_ph;
        byte_done    = s_ff.nib_ph;
        if (!s_ff.nib_ph) nxt_s.nib_byte = fifo_od;
      end else if (s_ff.fmt != fmt_adpcm && fifo_ov) begin
        fifo_pop     = 1'b1;
        byte_done    = 1'b1;
        nxt_s.pb_smp = (s_ff.fmt == fmt_mulaw) ? mulaw_dec(fifo_od) : {fifo_od, 8'h00};
      end
    end

    if (byte_done) begin
      nxt_s.ptr    = `MAE_AW'(s_ff.ptr + 1'b1);
      nxt_s.played = `MAE_LEN_W'(s_ff.played + 1'b1);
      if (nxt_s.played == s_ff.pb_len) begin
        if (s_ff.loop) begin
          nxt_s.ptr    = s_ff.pb_start;
          nxt_s.played = '0;
        end else begin
          nxt_s.pb_play = 1'b0;
          nxt_s.pb_smp  = '0;
        end
      end
    end

    // one read in flight and room checked before issue, so the push never overflows
    if (s_ff.pb_play && !s_ff.inflight && fifo_ir) begin
      if (s_ff.f_left != '0) begin
        nxt_s.inflight = 1'b1;
        nxt_s.f_addr   = `MAE_AW'(s_ff.f_addr + 1'b1);
        nxt_s.f_left   = `MAE_LEN_W'(s_ff.f_left - 1'b1);
      end else if (s_ff.loop) begin
        nxt_s.f_addr = s_ff.pb_start;
        nxt_s.f_left = s_ff.pb_len;
      end
    end

    // register writes come last so a restart wins over an end in the same cycle
    if (wr_hit) begin
      case (reg_req_i.addr)
        `MAE_A_EFFECT:   nxt_s.effect = reg_req_i.wdata[15:0];
        `MAE_A_SYN_TRIG: begin
          if (reg_req_i.wdata[0]) begin
            nxt_s.syn_play = (s_ff.effect[7:0] != '0);
            nxt_s.syn_ph   = '0;
            nxt_s.syn_cnt  = '0;
          end
        end
        `MAE_A_SYN_VOL:  nxt_s.syn_vol = reg_req_i.wdata[7:0];
        `MAE_A_PB_START: nxt_s.pb_start = reg_req_i.wdata[`MAE_AW-1:0];
        `MAE_A_PB_LEN:   nxt_s.pb_len = reg_req_i.wdata[`MAE_LEN_W-1:0];
        `MAE_A_PB_RATE:  nxt_s.pb_rate = reg_req_i.wdata[`MAE_RATE_W-1:0];
        `MAE_A_PB_FMT:   nxt_s.fmt = mae_fmt_e'(reg_req_i.wdata[1:0]);
        `MAE_A_PB_LOOP:  nxt_s.loop = reg_req_i.wdata[0];
        `MAE_A_PB_VOL:   nxt_s.pb_vol = reg_req_i.wdata[7:0];
        `MAE_A_PB_TRIG: begin
          nxt_s.pb_play  = (s_ff.pb_len != '0);
          nxt_s.ptr      = s_ff.pb_start;
          nxt_s.f_addr   = s_ff.pb_start;
          nxt_s.f_left   = s_ff.pb_len;
          nxt_s.played   = '0;
          nxt_s.inflight = 1'b0;
          nxt_s.nib_ph   = 1'b0;
          nxt_s.adp      = '0;
          nxt_s.acc      = '0;
          nxt_s.pb_smp   = '0;
          flush          = 1'b1;
        end
        default: ;
      endcase
    end

    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `MAE_A_EFFECT:   nxt_s.rdata = 32'(s_ff.effect);
        `MAE_A_SYN_TRIG: nxt_s.rdata = 32'(s_ff.syn_play);
        `MAE_A_SYN_VOL:  nxt_s.rdata = 32'(s_ff.syn_vol);
        `MAE_A_PB_START: nxt_s.rdata = 32'(s_ff.pb_start);
        `MAE_A_PB_LEN:   nxt_s.rdata = 32'(s_ff.pb_len);
        `MAE_A_PB_RATE:  nxt_s.rdata = 32'(s_ff.pb_rate);
        `MAE_A_PB_FMT:   nxt_s.rdata = 32'(s_ff.fmt);
        `MAE_A_PB_LOOP:  nxt_s.rdata = 32'(s_ff.loop);
        `MAE_A_PB_TRIG:  nxt_s.rdata = 32'(s_ff.pb_play);
        `MAE_A_PB_VOL:   nxt_s.rdata = 32'(s_ff.pb_vol);
        `MAE_A_PB_PTR:   nxt_s.rdata = 32'(s_ff.ptr);
        default:         nxt_s.rdata = '0;
      endcase
    end

    // duty only changes at a period boundary to avoid runt pulses
    nxt_s.pwm_cnt = 8'(s_ff.pwm_cnt + 1'b1);
    if (s_ff.pwm_cnt == 8'hFF) nxt_s.duty = mix[15:8] ^ 8'h80;
    nxt_s.pwm = (s_ff.pwm_cnt < s_ff.duty);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  assign reg_rdata_o = s_ff.rdata;
  assign audio_pwm_o = s_ff.pwm;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  pb_trig_start_a: assert property (wr_hit && reg_req_i.addr == `MAE_A_PB_TRIG && s_ff.pb_len != '0
    |=> s_ff.pb_play && s_ff.ptr == $past(s_ff.pb_start)) else $error("playback trigger did not start");
  syn_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `MAE_A_SYN_TRIG
    |=> s_ff.rdata == 32'($past(s_ff.syn_play))) else $error("synth trigger readback wrong");
  pb_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `MAE_A_PB_TRIG
    |=> s_ff.rdata == 32'($past(s_ff.pb_play))) else $error("playback trigger readback wrong");
  silence_stop_a: assert property (wr_hit && reg_req_i.addr == `MAE_A_SYN_TRIG && reg_req_i.wdata[0]
    && s_ff.effect[7:0] == '0 |=> !s_ff.syn_play [*2]) else $error("silence did not stop synth");
  loop_wrap_a: assert property (byte_done && s_ff.played == `MAE_LEN_W'(s_ff.pb_len - 1'b1) && s_ff.loop
    && !wr_hit |=> s_ff.ptr == $past(s_ff.pb_start) && s_ff.pb_play) else $error("loop did not wrap");
  once_stop_a: assert property (byte_done && s_ff.played == `MAE_LEN_W'(s_ff.pb_len - 1'b1) && !s_ff.loop
    && !wr_hit |=> !s_ff.pb_play) else $error("single play did not stop");
  ptr_step_a: assert property (byte_done && s_ff.played != `MAE_LEN_W'(s_ff.pb_len - 1'b1) && !wr_hit
    |=> s_ff.ptr == `MAE_AW'($past(s_ff.ptr) + 1'b1)) else $error("read pointer did not step");
  adpcm_pair_a: assert property (tick && s_ff.fmt == fmt_adpcm && !s_ff.nib_ph && fifo_ov && !wr_hit
    |=> s_ff.nib_ph && s_ff.nib_byte == $past(fifo_od)) else $error("adpcm low nibble not first");
  fetch_stall_a: assert property (!fifo_ir |=> !s_ff.inflight) else $error("fetch issued into full fifo");
  pwm_idle_a: assert property (s_ff.duty == 8'h00 && $past(s_ff.duty) == 8'h00 |-> !s_ff.pwm)
    else $error("pwm high at zero duty");

  loop_wrap_c: cover property (byte_done && s_ff.loop && s_ff.played == `MAE_LEN_W'(s_ff.pb_len - 1'b1));
  shot_end_c: cover property (s_ff.syn_play ##1 !s_ff.syn_play);
  adpcm_play_c: cover property (tick && s_ff.fmt == fmt_adpcm && s_ff.nib_ph);
  mulaw_play_c: cover property (tick && s_ff.fmt == fmt_mulaw && fifo_ov);
endmodule
`default_nettype wire

/* File: verification/mae_filter_model.sv */
`default_nettype none
module mae_filter_model (
  input  wire logic       clk_i,
  input  wire logic       pwm_i,
  output logic      [8:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // any 256-clock window of a 256-clock period holds exactly the duty count,
  // so the reading does not depend on where the pwm period starts
  logic [255:0] hist_ff;
  logic         pwm_b;
  // an unknown pin before reset counts as low, else the running sum never recovers
  assign pwm_b = (pwm_i === 1'b1);
  initial begin
    hist_ff = '0;
    level_o = '0;
  end
  always @(posedge clk_i) begin
    hist_ff <= {hist_ff[254:0], pwm_b};
    level_o <= level_o + 9'(pwm_b) - 9'(hist_ff[255]);
  end
endmodule
`default_nettype wire

/* File: verification/mae_top_test.sv */
`include "mae_params.svh"
`default_nettype none
module mae_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mae_pkg::*;
  typedef struct packed {logic [31:0] lo; logic [31:0] hi;} mae_note_s;
  localparam int SHOT = 200;
  // 1 MHz: one sample every 250 clocks
  localparam logic [19:0] RATE = 20'hF4240;
  logic         mclk_i   = 1'b0;
  logic         arst_n_i = 1'b0;
  mae_reg_req_s req      = '0;
  mae_ram_wr_s  ram      = '0;
  logic [31:0]  rdata;
  logic         pwm;
  logic [8:0]   level;
  logic         rd_ff    = 1'b0;
  mae_note_s    q[$];
  mae_note_s    cur;
  int           fail_count = 0;
  int           cmp_count  = 0;
  int           seed       = 9;
  logic [7:0]   regs [12] = '{`MAE_A_EFFECT, `MAE_A_SYN_TRIG, `MAE_A_SYN_VOL, `MAE_A_PB_START,
    `MAE_A_PB_LEN, `MAE_A_PB_RATE, `MAE_A_PB_FMT, `MAE_A_PB_LOOP, `MAE_A_PB_TRIG, `MAE_A_PB_VOL,
    `MAE_A_PB_PTR, 8'h2C};
  logic [7:0]   rwa [8] = '{`MAE_A_EFFECT, `MAE_A_SYN_VOL, `MAE_A_PB_START, `MAE_A_PB_LEN,
    `MAE_A_PB_RATE, `MAE_A_PB_FMT, `MAE_A_PB_LOOP, `MAE_A_PB_VOL};
  logic [31:0]  rwm [8] = '{32'hFFFF, 32'hFF, 32'hFFF, 32'hFFFF, 32'hFFFFF, 32'h3, 32'h1, 32'hFF};

  mae_top #(.SHOT_CYC(SHOT)) uut (
    .mclk_i      (mclk_i),
    .arst_n_i    (arst_n_i),
    .reg_req_i   (req),
    .ram_wr_i    (ram),
    .reg_rdata_o (rdata),
    .audio_pwm_o (pwm)
  );
  mae_filter_model filt (
    .clk_i   (mclk_i),
    .pwm_i   (pwm),
    .level_o (level)
  );

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask

  // the note goes in first; the monitor takes it on the falling edge half a cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    q.push_back('{lo, hi});
    @(posedge mclk_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk_i);
    req.rd <= 1'b0;
  endtask

  task automatic play(input logic [1:0] f, input logic lp, input logic [7:0] b, input logic [15:0] n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      ram.wr <= 1'b1;
      ram.addr <= 12'h100 + 12'(i);
      ram.data <= b;
    end
    @(posedge mclk_i);
    ram.wr <= 1'b0;
    wr(`MAE_A_PB_START, 32'h100);
    wr(`MAE_A_PB_LEN, 32'(n));
    wr(`MAE_A_PB_RATE, 32'(RATE));
    wr(`MAE_A_PB_FMT, 32'(f));
    wr(`MAE_A_PB_LOOP, 32'(lp));
    wr(`MAE_A_PB_TRIG, 32'h0);
  endtask

  always @(posedge mclk_i) rd_ff <= req.rd;
  always @(negedge mclk_i) begin
    if (rd_ff) begin
      cur = q.pop_front();
      if (cur.lo == cur.hi) begin
        check(rdata, cur.lo);
      end else begin
        check(32'(rdata >= cur.lo && rdata <= cur.hi), 32'h1);
      end
    end
  end

  initial begin
    repeat (40000) @(posedge mclk_i);
    fail_count++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    cyc(12);
    arst_n_i <= 1'b1;
    cyc(4);
    foreach (regs[i]) rd(regs[i], 32'h0, 32'h0);
    wr(`MAE_A_PB_PTR, 32'hFFFFFFFF);
    rd(`MAE_A_PB_PTR, 32'h0, 32'h0);
    wr(8'h2C, 32'hFFFFFFFF);
    rd(8'h2C, 32'h0, 32'h0);
    foreach (rwa[i]) begin
      d = $random(seed);
      wr(rwa[i], d);
      rd(rwa[i], d & rwm[i], d & rwm[i]);
    end
    wr(`MAE_A_SYN_VOL, 32'h0);
    wr(`MAE_A_PB_VOL, 32'h0);
    // host loads the code first, then triggers
    wr(`MAE_A_EFFECT, 32'h0);
    wr(`MAE_A_SYN_TRIG, 32'h1);
    rd(`MAE_A_SYN_TRIG, 32'h0, 32'h0);
    wr(`MAE_A_EFFECT, 32'h5541);
    wr(`MAE_A_SYN_TRIG, 32'h1);
    rd(`MAE_A_SYN_TRIG, 32'h1, 32'h1);
    cyc(SHOT + 20);
    rd(`MAE_A_SYN_TRIG, 32'h0, 32'h0);
    wr(`MAE_A_SYN_TRIG, 32'h2);
    rd(`MAE_A_SYN_TRIG, 32'h0, 32'h0);
    wr(`MAE_A_EFFECT, 32'h0C01);
    wr(`MAE_A_SYN_TRIG, 32'h1);
    cyc(SHOT * 2);
    rd(`MAE_A_SYN_TRIG, 32'h1, 32'h1);
    check(32'(level), 32'd128);
    wr(`MAE_A_EFFECT, 32'h0);
    wr(`MAE_A_SYN_TRIG, 32'h1);
    rd(`MAE_A_SYN_TRIG, 32'h0, 32'h0);
    play(fmt_linear, 1'b0, 8'h7F, 16'd4);
    cyc(600);
    rd(`MAE_A_PB_PTR, 32'h101, 32'h103);
    cyc(200);
    rd(`MAE_A_PB_TRIG, 32'h1, 32'h1);
    cyc(600);
    rd(`MAE_A_PB_TRIG, 32'h0, 32'h0);
    // two nibbles per byte: same length takes twice as long
    play(fmt_adpcm, 1'b0, 8'h00, 16'd4);
    cyc(1700);
    rd(`MAE_A_PB_TRIG, 32'h1, 32'h1);
    cyc(700);
    rd(`MAE_A_PB_TRIG, 32'h0, 32'h0);
    play(fmt_linear, 1'b0, 8'h7F, 16'd0);
    rd(`MAE_A_PB_TRIG, 32'h0, 32'h0);
    wr(`MAE_A_PB_VOL, 32'hFF);
    play(fmt_linear, 1'b1, 8'h7F, 16'd4);
    cyc(1500);
    rd(`MAE_A_PB_TRIG, 32'h1, 32'h1);
    rd(`MAE_A_PB_PTR, 32'h100, 32'h103);
    check(32'(level >= 9'd192), 32'h1);
    wr(`MAE_A_PB_VOL, 32'h0);
    cyc(600);
    check(32'(level), 32'd128);
    wr(`MAE_A_PB_VOL, 32'hFF);
    play(fmt_linear, 1'b1, 8'h80, 16'd4);
    cyc(800);
    check(32'(level < 9'd64), 32'h1);
    play(fmt_mulaw, 1'b1, 8'hFF, 16'd4);
    cyc(800);
    check(32'(level >= 9'd120 && level <= 9'd136), 32'h1);
    play(fmt_mulaw, 1'b1, 8'h00, 16'd4);
    cyc(800);
    check(32'(level > 9'd192 || level < 9'd64), 32'h1);
    // second reset in mid-playback
    arst_n_i <= 1'b0;
    cyc(3);
    arst_n_i <= 1'b1;
    cyc(4);
    rd(`MAE_A_PB_TRIG, 32'h0, 32'h0);
    rd(`MAE_A_PB_VOL, 32'h0, 32'h0);
    cyc(4);
    check(32'(q.size()), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
